// [rtl/uepf_pkg.sv]
// constants for the usb endpoint summary-flag block (endpoints 2 to 5)
// assumes an apb master on the same clock as the core and the endpoint status logic
//
// Operation
// - any active endpoint interrupt source sets that endpoint's summary flag.
// - endpoint 4 summary flag reads at bit 4 of the summary register.
// - endpoint 3 summary flag reads at bit 3 of the summary register.
// - endpoint 5 flag sits at bit 5, requests usb interrupt when enabled.
// - five sources count: transmit complete, out bank 0/1, setup, stall-or-crc.
// - usb interrupt for endpoint 4 only while its flag and enable are set.
// - hardware clears a summary flag only once all its sources are clear.
package uepf_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FIRST_EP = 2;
	localparam int NUM_EP = 4;
	localparam int NUM_SRC = 5;

	// ----------------------------------------------------------------
	// source bit positions inside one endpoint's source vector
	// ----------------------------------------------------------------
	localparam int SRC_TX_CMP = 0;
	localparam int SRC_RX_B0 = 1;
	localparam int SRC_RX_B1 = 2;
	localparam int SRC_SETUP = 3;
	localparam int SRC_STALL_CRC = 4;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_SUMMARY = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h0C;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [NUM_EP-1:0] RST_FLAGS = 4'h0;
	localparam logic [NUM_EP-1:0] RST_ENABLE = 4'h0;
	localparam logic [NUM_EP-1:0] RST_EVT_STAT = 4'h0;
	localparam logic [NUM_EP-1:0] RST_EVT_MASK = 4'h0;
	localparam logic [DATA_W-1:0] RST_PRDATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		UEPF_SEL_SUMMARY,
		UEPF_SEL_ENABLE,
		UEPF_SEL_EVT_STAT,
		UEPF_SEL_EVT_MASK
	} uepf_sel_t;

endpackage : uepf_pkg

// [rtl/uepf_flag_cell.sv]
// one endpoint's summary flag, tracking the or of its interrupt sources
// assumes sources come from status logic on the same clock, held until software clears them
module uepf_flag_cell import uepf_pkg::*; #(
	parameter int SRC_W = uepf_pkg::NUM_SRC
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// sources
	input wire logic [SRC_W-1:0] src,
	// flag
	output logic flag_q,
	output logic flag_rise
);

	logic flag_d;

	// any one of the sources is enough; all must drop before the flag drops
	assign flag_d = |src;
	assign flag_rise = ce & flag_d & ~flag_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= 1'b0;
		end else if (ce) begin
			flag_q <= flag_d;
		end
	end

endmodule : uepf_flag_cell

// [rtl/uepf_top.sv]
// usb endpoint summary flags for endpoints 2 to 5, with apb register access
// assumes per-endpoint source levels on CORE_CLK and an apb master on CORE_CLK
module uepf_top import uepf_pkg::*; #(
	parameter int NUM_EP_P = uepf_pkg::NUM_EP,
	parameter int FIRST_EP_P = uepf_pkg::FIRST_EP
) (
	// clock, reset, enable
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic CE,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [uepf_pkg::ADDR_W-1:0] PADDR,
	input wire logic [uepf_pkg::DATA_W-1:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [uepf_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// endpoint interrupt sources, bit 0 is the lowest endpoint
	input wire logic [NUM_EP_P-1:0] TRANSMIT_COMPLETE,
	input wire logic [NUM_EP_P-1:0] RECEIVE_OUT_BANK0,
	input wire logic [NUM_EP_P-1:0] RECEIVE_OUT_BANK1,
	input wire logic [NUM_EP_P-1:0] SETUP_RECEIVED,
	input wire logic [NUM_EP_P-1:0] STALL_OR_CRC_ERROR,
	// interrupts
	output logic USB_IRQ,
	output logic EVT_IRQ
);
	import uepf_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// all flags must fit in the low byte so one byte lane carries them
	if (NUM_EP_P < 1 || FIRST_EP_P < 0 || FIRST_EP_P + NUM_EP_P > 8) begin : g_bad_geometry
		$error("endpoint range does not fit the low byte");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] place(input logic [NUM_EP_P-1:0] v);
		logic [DATA_W-1:0] w;
		w = '0;
		w[FIRST_EP_P +: NUM_EP_P] = v;
		return w;
	endfunction : place

	function automatic logic decode(input logic [ADDR_W-1:0] a, output uepf_sel_t s);
		decode = 1'b1;
		s = UEPF_SEL_SUMMARY;
		if (a == OFS_SUMMARY) begin
			s = UEPF_SEL_SUMMARY;
		end else if (a == OFS_ENABLE) begin
			s = UEPF_SEL_ENABLE;
		end else if (a == OFS_EVT_STAT) begin
			s = UEPF_SEL_EVT_STAT;
		end else if (a == OFS_EVT_MASK) begin
			s = UEPF_SEL_EVT_MASK;
		end else begin
			decode = 1'b0;
		end
	endfunction : decode

	// ----------------------------------------------------------------
	// summary flags
	// ----------------------------------------------------------------
	logic [NUM_EP_P-1:0] flag_q;
	logic [NUM_EP_P-1:0] flag_rise;
	logic [NUM_EP_P-1:0] any_src;

	for (genvar i = 0; i < NUM_EP_P; i++) begin : g_ep
		logic [NUM_SRC-1:0] src;
		always_comb begin
			src = '0;
			src[SRC_TX_CMP] = TRANSMIT_COMPLETE[i];
			src[SRC_RX_B0] = RECEIVE_OUT_BANK0[i];
			src[SRC_RX_B1] = RECEIVE_OUT_BANK1[i];
			src[SRC_SETUP] = SETUP_RECEIVED[i];
			src[SRC_STALL_CRC] = STALL_OR_CRC_ERROR[i];
		end
		assign any_src[i] = |src;
		uepf_flag_cell #(
			.SRC_W(NUM_SRC)
		) u_cell (
			.clk(CORE_CLK),
			.arst_n(ARST_N),
			.ce(CE),
			.src(src),
			.flag_q(flag_q[i]),
			.flag_rise(flag_rise[i])
		);
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// one wait state: the read word is captured first, completion follows
	logic pready_q;
	logic [DATA_W-1:0] prdata_q;
	logic pslverr_q;
	uepf_sel_t sel;
	logic hit;
	logic access;
	logic wr_done;
	logic rd_done;

	always_comb begin
		sel = UEPF_SEL_SUMMARY;
		hit = decode(PADDR, sel);
	end

	assign access = CE & PSEL & PENABLE;
	assign wr_done = access & pready_q & PWRITE & hit & PSTRB[0];
	assign rd_done = access & pready_q & ~PWRITE & hit;

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	logic [NUM_EP_P-1:0] enable_q;
	logic [NUM_EP_P-1:0] evt_stat_q;
	logic [NUM_EP_P-1:0] evt_mask_q;

	// summary flags have no write path at all
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			enable_q <= RST_ENABLE;
		end else if (wr_done && sel == UEPF_SEL_ENABLE) begin
			enable_q <= PWDATA[FIRST_EP_P +: NUM_EP_P];
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			evt_mask_q <= RST_EVT_MASK;
		end else if (wr_done && sel == UEPF_SEL_EVT_MASK) begin
			evt_mask_q <= PWDATA[FIRST_EP_P +: NUM_EP_P];
		end
	end

	// only the bits handed out in the read word are cleared, so a rise that lands
	// between capture and completion is not lost; a rise in the clearing cycle stays set
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			evt_stat_q <= RST_EVT_STAT;
		end else if (CE) begin
			if (rd_done && sel == UEPF_SEL_EVT_STAT) begin
				evt_stat_q <= (evt_stat_q & ~prdata_q[FIRST_EP_P +: NUM_EP_P]) | flag_rise;
			end else begin
				evt_stat_q <= evt_stat_q | flag_rise;
			end
		end
	end

	// ----------------------------------------------------------------
	// apb response
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pready_q <= 1'b0;
		end else if (CE) begin
			pready_q <= PSEL & PENABLE & ~pready_q;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prdata_q <= RST_PRDATA;
			pslverr_q <= 1'b0;
		end else if (access && !pready_q) begin
			pslverr_q <= ~hit;
			prdata_q <= RST_PRDATA;
			if (hit && !PWRITE) begin
				unique case (sel)
					UEPF_SEL_SUMMARY: prdata_q <= place(flag_q);
					UEPF_SEL_ENABLE: prdata_q <= place(enable_q);
					UEPF_SEL_EVT_STAT: prdata_q <= place(evt_stat_q);
					UEPF_SEL_EVT_MASK: prdata_q <= place(evt_mask_q);
				endcase
			end
		end
	end

	assign PREADY = pready_q;
	assign PRDATA = prdata_q;
	assign PSLVERR = pslverr_q;

	// ----------------------------------------------------------------
	// interrupt outputs
	// ----------------------------------------------------------------
	logic usb_irq_q;
	logic evt_irq_q;

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			usb_irq_q <= 1'b0;
			evt_irq_q <= 1'b0;
		end else if (CE) begin
			usb_irq_q <= |(flag_q & enable_q);
			evt_irq_q <= |(evt_stat_q & evt_mask_q);
		end
	end

	assign USB_IRQ = usb_irq_q;
	assign EVT_IRQ = evt_irq_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	localparam int E3 = 3 - FIRST_EP_P;
	localparam int E4 = 4 - FIRST_EP_P;
	localparam int E5 = 5 - FIRST_EP_P;

	logic rd_capture;
	assign rd_capture = access & ~pready_q & ~PWRITE & hit & (sel == UEPF_SEL_SUMMARY);

	property p_flag_set;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		CE |=> ((flag_q & $past(any_src)) == $past(any_src));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("source active but flag not set");

	property p_ep4_bit;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		rd_capture |=> PREADY && (PRDATA[4] == $past(flag_q[E4]));
	endproperty
	a_ep4_bit: assert property (p_ep4_bit) else $error("endpoint 4 flag not at bit 4");

	property p_ep3_bit;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		rd_capture |=> PRDATA[3] == $past(flag_q[E3]);
	endproperty
	a_ep3_bit: assert property (p_ep3_bit) else $error("endpoint 3 flag not at bit 3");

	property p_ep5_irq;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		CE && flag_q[E5] && enable_q[E5] |=> USB_IRQ;
	endproperty
	a_ep5_irq: assert property (p_ep5_irq) else $error("endpoint 5 request not raised");

	property p_ep5_bit;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		rd_capture |=> PRDATA[5] == $past(flag_q[E5]);
	endproperty
	a_ep5_bit: assert property (p_ep5_bit) else $error("endpoint 5 flag not at bit 5");

	property p_stall_src;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(CE && STALL_OR_CRC_ERROR[E4] && !TRANSMIT_COMPLETE[E4]) ##1 CE |-> flag_q[E4] ##1 1'b1;
	endproperty
	a_stall_src: assert property (p_stall_src) else $error("stall or crc source ignored");

	property p_ep4_gate;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		CE && flag_q[E4] && enable_q[E4] |=> USB_IRQ;
	endproperty
	a_ep4_gate: assert property (p_ep4_gate) else $error("endpoint 4 request not raised");

	property p_ep4_block;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(CE && !(flag_q[E4] && enable_q[E4]) && ((flag_q & enable_q) == '0)) |=> !USB_IRQ;
	endproperty
	a_ep4_block: assert property (p_ep4_block) else $error("usb request without enabled flag");

	property p_flag_clear;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		CE |=> ((flag_q & ~$past(any_src)) == '0);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag held without any source");

	property p_flag_ro;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(wr_done && sel == UEPF_SEL_SUMMARY) |=> ((flag_q & ~$past(any_src)) == '0);
	endproperty
	a_flag_ro: assert property (p_flag_ro) else $error("write changed a summary flag");

	property p_enable_wr;
		@(posedge CORE_CLK) disable iff (!ARST_N)
		(wr_done && sel == UEPF_SEL_ENABLE) |=> enable_q == $past(PWDATA[FIRST_EP_P +: NUM_EP_P]);
	endproperty
	a_enable_wr: assert property (p_enable_wr) else $error("enable write lost");

	c_ep4_irq: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		flag_q[E4] && enable_q[E4] ##1 USB_IRQ);
	c_flag_drop: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		flag_q[E5] ##1 !flag_q[E5]);
	c_summary_rd: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		rd_capture ##1 PREADY);
	c_evt_irq: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
		rd_done && sel == UEPF_SEL_EVT_STAT && EVT_IRQ);

endmodule : uepf_top

// [dv/uepf_top_test.sv]
// self-checking bench for the usb endpoint summary-flag block, endpoints 2 to 5
// assumes uepf_pkg and uepf_top compiled first; assertions live in the design files
module uepf_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import uepf_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic core_clk;
	logic arst_n;
	logic ce;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [3:0] pstrb;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] tx_cmp, rx_b0, rx_b1, setup_rx, stall_crc;
	logic usb_irq;
	logic evt_irq;
	logic [31:0] rd_data;
	logic rd_err;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;

	uepf_top DUT (
		.CORE_CLK(core_clk), .ARST_N(arst_n), .CE(ce),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TRANSMIT_COMPLETE(tx_cmp), .RECEIVE_OUT_BANK0(rx_b0),
		.RECEIVE_OUT_BANK1(rx_b1), .SETUP_RECEIVED(setup_rx),
		.STALL_OR_CRC_ERROR(stall_crc), .USB_IRQ(usb_irq), .EVT_IRQ(evt_irq)
	);

	// ----------------------------------------------------------------
	// clock, timeout, report
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	// the whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp32

	task automatic cmp1(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp1

	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wait_n

	// one apb transfer; the request stays put until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= adr;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk_rd(input string what, input logic [7:0] adr, input logic [31:0] exp);
		apb(1'b0, adr, 32'h0000_0000);
		cmp32(what, exp, rd_data);
		cmp1({what, " error"}, 1'b0, rd_err);
	endtask : chk_rd

	task automatic set_src(input int s, input logic [3:0] v);
		case (s)
			0: tx_cmp <= v;
			1: rx_b0 <= v;
			2: rx_b1 <= v;
			3: setup_rx <= v;
			default: stall_crc <= v;
		endcase
	endtask : set_src

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk_rd("summary", OFS_SUMMARY, 32'h0000_0000);
		chk_rd("enable", OFS_ENABLE, 32'h0000_0000);
		chk_rd("event status", OFS_EVT_STAT, 32'h0000_0000);
		chk_rd("event mask", OFS_EVT_MASK, 32'h0000_0000);
		cmp1("usb irq", 1'b0, usb_irq);
	endtask : t_reset

	// every source of every endpoint alone sets just that endpoint's bit
	task automatic t_each_source;
		for (int e = 0; e < 4; e++) begin
			for (int s = 0; s < 5; s++) begin
				set_src(s, 4'h1 << e);
				wait_n(3);
				chk_rd("summary set", OFS_SUMMARY, 32'h1 << (e + 2));
				set_src(s, 4'h0);
				wait_n(2);
				chk_rd("summary clear", OFS_SUMMARY, 32'h0000_0000);
			end
		end
	endtask : t_each_source

	task automatic t_partial;
		tx_cmp <= 4'h2;
		stall_crc <= 4'h2;
		wait_n(3);
		tx_cmp <= 4'h0;
		wait_n(3);
		chk_rd("one source left", OFS_SUMMARY, 32'h0000_0008);
		stall_crc <= 4'h0;
		wait_n(3);
		chk_rd("all sources gone", OFS_SUMMARY, 32'h0000_0000);
	endtask : t_partial

	task automatic t_usb_irq;
		rx_b1 <= 4'hC;
		wait_n(3);
		cmp1("usb irq disabled", 1'b0, usb_irq);
		apb(1'b1, OFS_ENABLE, 32'h0000_0010);
		wait_n(2);
		cmp1("usb irq ep4", 1'b1, usb_irq);
		chk_rd("enable", OFS_ENABLE, 32'h0000_0010);
		apb(1'b1, OFS_ENABLE, 32'h0000_002C);
		wait_n(2);
		cmp1("usb irq ep5", 1'b1, usb_irq);
		rx_b1 <= 4'h4;
		wait_n(3);
		cmp1("usb irq ep4 off", 1'b0, usb_irq);
		apb(1'b1, OFS_ENABLE, 32'h0000_0010);
		wait_n(2);
		cmp1("usb irq ep4 on", 1'b1, usb_irq);
		apb(1'b1, OFS_ENABLE, 32'h0000_0000);
		wait_n(2);
		cmp1("usb irq blocked", 1'b0, usb_irq);
		rx_b1 <= 4'h0;
	endtask : t_usb_irq

	task automatic t_read_only;
		tx_cmp <= 4'h1;
		wait_n(3);
		apb(1'b1, OFS_SUMMARY, 32'hFFFF_FFFF);
		chk_rd("summary after write", OFS_SUMMARY, 32'h0000_0004);
		apb(1'b0, 8'h10, 32'h0000_0000);
		cmp1("unmapped error", 1'b1, rd_err);
		cmp32("unmapped data", 32'h0000_0000, rd_data);
		tx_cmp <= 4'h0;
		wait_n(3);
	endtask : t_read_only

	// a flag rise latches a read-to-clear event bit; only masked-in bits raise the line
	task automatic t_events;
		apb(1'b0, OFS_EVT_STAT, 32'h0000_0000);
		apb(1'b1, OFS_EVT_MASK, 32'h0000_0008);
		setup_rx <= 4'h2;
		wait_n(3);
		cmp1("event irq", 1'b1, evt_irq);
		chk_rd("event status", OFS_EVT_STAT, 32'h0000_0008);
		wait_n(2);
		cmp1("event irq cleared", 1'b0, evt_irq);
		chk_rd("event status cleared", OFS_EVT_STAT, 32'h0000_0000);
		setup_rx <= 4'h3;
		wait_n(3);
		cmp1("event irq masked", 1'b0, evt_irq);
		chk_rd("event status ep2", OFS_EVT_STAT, 32'h0000_0004);
		setup_rx <= 4'h0;
	endtask : t_events

	// ce low freezes state; a write without lane 0 is ignored; a mid-run reset clears all
	task automatic t_freeze_reset;
		apb(1'b1, OFS_ENABLE, 32'h0000_0004);
		ce <= 1'b0;
		tx_cmp <= 4'h1;
		wait_n(3);
		cmp1("usb irq frozen", 1'b0, usb_irq);
		ce <= 1'b1;
		wait_n(3);
		cmp1("usb irq after freeze", 1'b1, usb_irq);
		pstrb <= 4'hE;
		apb(1'b1, OFS_ENABLE, 32'h0000_003C);
		pstrb <= 4'hF;
		chk_rd("enable lane 0 off", OFS_ENABLE, 32'h0000_0004);
		arst_n <= 1'b0;
		wait_n(2);
		cmp1("usb irq in reset", 1'b0, usb_irq);
		tx_cmp <= 4'h0;
		arst_n <= 1'b1;
		chk_rd("summary after reset", OFS_SUMMARY, 32'h0000_0000);
		chk_rd("enable after reset", OFS_ENABLE, 32'h0000_0000);
	endtask : t_freeze_reset

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		{tx_cmp, rx_b0, rx_b1, setup_rx, stall_crc} = '0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset();
		t_each_source();
		t_partial();
		t_usb_irq();
		t_read_only();
		t_events();
		t_freeze_reset();
		end_sim();
	end

endmodule : uepf_top_test
